// ===== sleep_wakeup_map.svh
// Addresses, field positions, reset values and timing counts for sleep control.
`ifndef SLEEP_WAKEUP_MAP_SVH
`define SLEEP_WAKEUP_MAP_SVH

`define OPT_ADDR     8'h81
`define OPT_RESET    8'hFF
`define OPT_PSA      3
`define OPT_PS_HI    2
`define OPT_PS_LO    0

`define CFG_ADDR     14'h2007
`define CFG_RESET    8'hFF
`define CFG_MASTER_CLEAR_ENABLE    7
`define CFG_CP_HI    6
`define CFG_CP_LO    5
`define CFG_WATCHDOG_ENABLE_CFG     3
`define CFG_RC_MODE  2
`define CP_OFF       2'h3

`define STATUS_PD    3
`define STATUS_TO    4
`define STATUS_RESET 8'h18

`define ID_BASE      14'h2000
`define ID_LAST      14'h2003
`define ID_COUNT     4
`define ID_IDX_W     2
`define PC_START     14'h0000
`define VEC_ADDR     14'h0004

`define CMD_W        6
`define DATA_W       14
`define CMD_LAST     5'h05
`define DATA_LAST    5'h0D
`define DATA_CNT     5'h0E
`define CMD_LOAD     6'h02
`define CMD_READ     6'h04
`define CMD_INC      6'h06
`define CMD_LOAD_CFG 6'h01

`define TOSC_NS      8
`define MCLK_NS      8
`define OST_TOSC     1024
`define OST_CYC      ((`OST_TOSC * `TOSC_NS + `MCLK_NS - 1) / `MCLK_NS)

`endif

// ===== sleep_wakeup_pkg.sv
// Types and command decoding shared by the sleep control modules.
`include "sleep_wakeup_map.svh"
package sleep_wakeup_pkg;
  typedef logic [`CMD_W-1:0]  cmd_t;
  typedef logic [`DATA_W-1:0] word_t;

  typedef enum logic [2:0] {
    ST_RUN    = 3'h0,
    ST_SLEEP  = 3'h1,
    ST_OST    = 3'h2,
    ST_NEXT   = 3'h3,
    ST_DUMMY1 = 3'h4,
    ST_DUMMY2 = 3'h5
  } pwr_state_e;

  function automatic logic has_data(input cmd_t c);
    return (c == `CMD_LOAD) || (c == `CMD_READ) || (c == `CMD_LOAD_CFG);
  endfunction
endpackage

// ===== prog_if.sv
// Command and data words between the serial programming shifter and the control.
`timescale 1ns/1ps
interface prog_if;
  import sleep_wakeup_pkg::*;
  logic  cmd_valid;
  cmd_t  cmd;
  logic  data_valid;
  word_t wdata;
  word_t rdata;
  logic  pins_low;

  modport link (output cmd_valid, cmd, data_valid, wdata, pins_low, input rdata);
  modport core (input cmd_valid, cmd, data_valid, wdata, pins_low, output rdata);
endinterface

// ===== prog_serial.sv
// Serial shifter for the two-wire programming link.
`timescale 1ns/1ps
`include "sleep_wakeup_map.svh"
module prog_serial (
  input  logic  mclk,
  input  logic  sys_rst,
  input  logic  prog_mode,
  input  logic  clock_pin,
  input  logic  data_pin,
  output logic  data_out,
  output logic  data_oe,
  prog_if.link  pl
);
  import sleep_wakeup_pkg::*;

  logic       ck_s1, ck_s2, ck_s3, dt_s1, dt_s2;
  logic       in_data, rd, load_pend;
  logic [4:0] cnt;
  cmd_t       cmd_sh;
  word_t      sh;

  wire  rise     = ck_s2 & ~ck_s3;
  wire  fall     = ~ck_s2 & ck_s3;
  cmd_t cmd_now;
  assign cmd_now = {dt_s2, cmd_sh[`CMD_W-1:1]};
  wire  cmd_done = rise & ~in_data & (cnt == `CMD_LAST);
  wire  dat_done = rise & in_data & ~rd & (cnt == `DATA_LAST);
  wire  rd_done  = fall & in_data & rd & (cnt == `DATA_CNT);

  assign pl.pins_low = ~ck_s2 & ~dt_s2;

  // The data pin passes two flops and the clock three; the edge detector compares the second and third clock stages.
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      {ck_s1, ck_s2, ck_s3, dt_s1, dt_s2} <= 5'h00;
    end else begin
      {ck_s1, ck_s2, ck_s3} <= {clock_pin, ck_s1, ck_s2};
      {dt_s1, dt_s2}        <= {data_pin, dt_s1};
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      pl.cmd_valid  <= 1'b0;
      pl.data_valid <= 1'b0;
      pl.cmd        <= '0;
      pl.wdata      <= '0;
      load_pend     <= 1'b0;
    end else begin
      pl.cmd_valid  <= prog_mode & cmd_done;
      pl.data_valid <= prog_mode & dat_done;
      pl.cmd        <= cmd_now;
      pl.wdata      <= {dt_s2, sh[`DATA_W-1:1]};
      load_pend     <= prog_mode & cmd_done & (cmd_now == `CMD_READ);
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      in_data  <= 1'b0;
      rd       <= 1'b0;
      cnt      <= 5'h00;
      cmd_sh   <= '0;
      sh       <= '0;
      data_out <= 1'b0;
      data_oe  <= 1'b0;
    end else if (!prog_mode) begin
      in_data <= 1'b0;
      rd      <= 1'b0;
      cnt     <= 5'h00;
      data_oe <= 1'b0;
    end else begin
      if (cmd_done) begin
        cnt     <= 5'h00;
        in_data <= has_data(cmd_now);
        rd      <= (cmd_now == `CMD_READ);
      end else if (dat_done || rd_done) begin
        cnt     <= 5'h00;
        in_data <= 1'b0;
      end else if (rise) begin
        cnt <= cnt + 5'h01;
      end
      if (rise && !in_data) begin
        cmd_sh <= cmd_now;
      end
      // Read words go out low bit first, changing on each rising clock.
      if (load_pend) begin
        sh <= pl.rdata;
      end else if (rise && in_data && !rd) begin
        sh <= {dt_s2, sh[`DATA_W-1:1]};
      end else if (rise && in_data && rd) begin
        data_out <= sh[0];
        sh       <= sh >> 1;
      end
      if (rise && in_data && rd) begin
        data_oe <= 1'b1;
      end else if (rd_done) begin
        data_oe <= 1'b0;
      end
    end
  end
endmodule // prog_serial

// ===== sleep_wakeup_control.sv
// Sleep entry, wake-up sequencing, watchdog and program/verify control.
`timescale 1ns/1ps
`include "sleep_wakeup_map.svh"
module sleep_wakeup_control #(
  parameter logic [7:0] WDT_BASE_TICKS = 8'hFF
) (
  input  logic                    mclk,
  input  logic                    sys_rst,
  input  logic                    sleep_exec,
  input  logic                    clear_watchdog_instr,
  input  logic                    global_irq_enable,
  input  logic                    ext_edge_irq_flag,
  input  logic                    ext_edge_irq_en,
  input  logic                    port_change_flag,
  input  logic                    port_change_en,
  input  logic                    adc_flag,
  input  logic                    adc_en,
  input  logic                    adc_rc_clock,
  input  logic [7:0]              reg_addr,
  input  logic                    reg_wr,
  input  logic [7:0]              reg_wdata,
  input  logic                    master_clear_pin_n,
  input  logic                    programming_high_level,
  input  logic                    wdt_rc_clock,
  input  logic                    prog_clock_pin,
  input  logic                    prog_data_pin,
  input  sleep_wakeup_pkg::word_t pmem_rdata,
  output logic [7:0]              reg_rdata,
  output logic [7:0]              status_flags,
  output logic                    osc_enable,
  output logic                    pin_hold,
  output logic                    sleeping,
  output logic                    prefetch_next,
  output logic                    resume_exec,
  output logic                    dummy_cycle,
  output logic                    vector_req,
  output sleep_wakeup_pkg::word_t vector_pc,
  output logic                    device_reset,
  output logic                    prog_mode,
  output logic                    prog_data_out,
  output logic                    prog_data_oe,
  output sleep_wakeup_pkg::word_t pmem_addr,
  output sleep_wakeup_pkg::word_t pmem_wdata,
  output logic                    pmem_wr
);
  import sleep_wakeup_pkg::*;

  localparam logic [10:0] OST_LAST = 11'(`OST_CYC - 1);
  localparam int          OST_CYC_I = `OST_CYC;

  function automatic logic is_id(input word_t a);
    return (a >= `ID_BASE) && (a <= `ID_LAST);
  endfunction

  function automatic logic is_pmem(input word_t a);
    return a < `ID_BASE;
  endfunction

  pwr_state_e  state, next_state;
  logic [7:0]  option, cfg, next_status, next_rdata;
  logic        master_clear_pin_s1, master_clear_pin_s2, hv_s1, hv_s2, hv_s3;
  logic        tk_s1, tk_s2, tk_s3, irq_woke;
  logic [15:0] wdt_cnt;
  logic [10:0] ost_cnt;
  cmd_t        cmd_last;
  word_t       id_mem [`ID_COUNT];
  word_t       next_prog_rdata;

  prog_if pl ();

  prog_serial u_serial (
    .mclk      (mclk),
    .sys_rst   (sys_rst),
    .prog_mode (prog_mode),
    .clock_pin (prog_clock_pin),
    .data_pin  (prog_data_pin),
    .data_out  (prog_data_out),
    .data_oe   (prog_data_oe),
    .pl        (pl.link)
  );

  // Configuration and option fields.
  wire       master_clear_enable = cfg[`CFG_MASTER_CLEAR_ENABLE];
  wire       watchdog_enable_cfg = cfg[`CFG_WATCHDOG_ENABLE_CFG];
  wire       rc_osc_mode         = cfg[`CFG_RC_MODE];
  wire       cp_off              = cfg[`CFG_CP_HI:`CFG_CP_LO] == `CP_OFF;
  wire       prescaler_assign    = option[`OPT_PSA];
  wire [2:0] prescale_sel        = option[`OPT_PS_HI:`OPT_PS_LO];

  // Wake-capable interrupt terms.
  wire irq_ext  = ext_edge_irq_flag & ext_edge_irq_en;
  wire irq_port = port_change_flag & port_change_en;
  wire irq_adc  = adc_flag & adc_en & adc_rc_clock;
  wire wake_irq = irq_ext | irq_port | irq_adc;

  // Sleep decisions.
  wire in_run    = state == ST_RUN;
  wire in_sleep  = state == ST_SLEEP;
  wire sleep_nop = sleep_exec & in_run & wake_irq & ~global_irq_enable;
  wire sleep_go  = sleep_exec & in_run & ~sleep_nop;
  wire master_clear_pin_rst  = master_clear_enable & ~master_clear_pin_s2 & ~prog_mode;

  // Watchdog counts ticks of its own RC clock, so it keeps running in sleep.
  wire        tick_rise = tk_s2 & ~tk_s3;
  wire        wdt_clr   = clear_watchdog_instr | sleep_go;
  wire [15:0] wdt_base  = {8'h00, WDT_BASE_TICKS};
  wire [15:0] wdt_limit = prescaler_assign ? (wdt_base << prescale_sel) : wdt_base;
  wire        wdt_to    = watchdog_enable_cfg & tick_rise & ~wdt_clr
                          & (wdt_cnt == wdt_limit - 16'h0001);
  wire        wake      = wake_irq | wdt_to;
  wire        ost_done  = ost_cnt == OST_LAST;

  // Programming link decoding.
  wire hv_rise  = hv_s2 & ~hv_s3;
  wire load_cmd = pl.data_valid & (cmd_last == `CMD_LOAD);
  wire opt_hit  = reg_addr == `OPT_ADDR;

  assign next_rdata = opt_hit ? option : 8'h00;

  always_comb begin
    if (is_id(pmem_addr)) begin
      next_prog_rdata = id_mem[pmem_addr[`ID_IDX_W-1:0]];
    end else if (pmem_addr == `CFG_ADDR) begin
      next_prog_rdata = {6'h00, cfg};
    end else if (is_pmem(pmem_addr) && cp_off) begin
      next_prog_rdata = pmem_rdata;
    end else begin
      next_prog_rdata = '0;
    end
  end

  always_comb begin
    next_state = state;
    unique case (state)
      ST_RUN: begin
        if (sleep_go) next_state = ST_SLEEP;
      end
      ST_SLEEP: begin
        if (wake) next_state = rc_osc_mode ? ST_NEXT : ST_OST;
      end
      ST_OST: begin
        if (ost_done) next_state = ST_NEXT;
      end
      ST_NEXT: begin
        next_state = (global_irq_enable & irq_woke) ? ST_DUMMY1 : ST_RUN;
      end
      ST_DUMMY1: begin
        next_state = ST_DUMMY2;
      end
      ST_DUMMY2: begin
        next_state = ST_RUN;
      end
      default: begin
        next_state = ST_RUN;
      end
    endcase
    if (master_clear_pin_rst) next_state = ST_RUN;
  end

  // A time-out that coincides with a clear is dropped, since the clear restarts the count.
  always_comb begin
    next_status = status_flags;
    if (clear_watchdog_instr) begin
      next_status[`STATUS_PD] = 1'b1;
      next_status[`STATUS_TO] = 1'b1;
    end
    if (sleep_go) begin
      next_status[`STATUS_PD] = 1'b0;
      next_status[`STATUS_TO] = 1'b1;
    end
    if (wdt_to) next_status[`STATUS_TO] = 1'b0;
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      {master_clear_pin_s1, master_clear_pin_s2} <= 2'h3;
      {hv_s1, hv_s2, hv_s3} <= 3'h0;
      {tk_s1, tk_s2, tk_s3} <= 3'h0;
    end else begin
      {master_clear_pin_s1, master_clear_pin_s2}    <= {master_clear_pin_n, master_clear_pin_s1};
      {hv_s1, hv_s2, hv_s3} <= {programming_high_level, hv_s1, hv_s2};
      {tk_s1, tk_s2, tk_s3} <= {wdt_rc_clock, tk_s1, tk_s2};
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      state        <= ST_RUN;
      status_flags <= `STATUS_RESET;
      irq_woke     <= 1'b0;
      ost_cnt      <= 11'h000;
      wdt_cnt      <= 16'h0000;
    end else begin
      state        <= next_state;
      status_flags <= next_status;
      if (in_sleep && wake) irq_woke <= wake_irq;
      ost_cnt <= (state == ST_OST) ? ost_cnt + 11'h001 : 11'h000;
      if (wdt_clr || wdt_to || !watchdog_enable_cfg) begin
        wdt_cnt <= 16'h0000;
      end else if (tick_rise) begin
        wdt_cnt <= wdt_cnt + 16'h0001;
      end
    end
  end

  // Sleep, hold, oscillator, resume and dummy outputs follow the next state so they line up with it; vector_req follows the present state.
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      sleeping      <= 1'b0;
      pin_hold      <= 1'b0;
      osc_enable    <= 1'b1;
      prefetch_next <= 1'b0;
      resume_exec   <= 1'b0;
      dummy_cycle   <= 1'b0;
      vector_req    <= 1'b0;
      vector_pc     <= '0;
      device_reset  <= 1'b0;
      reg_rdata     <= 8'h00;
    end else begin
      sleeping      <= next_state == ST_SLEEP;
      pin_hold      <= next_state == ST_SLEEP;
      osc_enable    <= next_state != ST_SLEEP;
      prefetch_next <= sleep_exec & in_run;
      resume_exec   <= next_state == ST_NEXT;
      dummy_cycle   <= (next_state == ST_DUMMY1) | (next_state == ST_DUMMY2);
      vector_req    <= (state == ST_DUMMY2) & ~master_clear_pin_rst;
      if (state == ST_DUMMY2) vector_pc <= `VEC_ADDR;
      device_reset  <= master_clear_pin_rst | (wdt_to & ~in_sleep);
      reg_rdata     <= next_rdata;
    end
  end

  // Option register; its value is applied at once, so clearing first is up to software.
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      option <= `OPT_RESET;
    end else if (reg_wr && opt_hit) begin
      option <= reg_wdata;
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      prog_mode <= 1'b0;
      pmem_addr <= `PC_START;
      cmd_last  <= '0;
      cfg       <= `CFG_RESET;
      pmem_wr   <= 1'b0;
      pmem_wdata <= '0;
      pl.rdata  <= '0;
      for (int i = 0; i < `ID_COUNT; i++) id_mem[i] <= '0;
    end else begin
      prog_mode  <= hv_s2 & (prog_mode | (hv_rise & pl.pins_low));
      pl.rdata   <= next_prog_rdata;
      pmem_wr    <= prog_mode & load_cmd & is_pmem(pmem_addr);
      pmem_wdata <= pl.wdata;
      if (!prog_mode) begin
        pmem_addr <= `PC_START;
      end else if (pl.cmd_valid) begin
        cmd_last <= pl.cmd;
        if (pl.cmd == `CMD_INC) pmem_addr <= pmem_addr + 14'h0001;
        if (pl.cmd == `CMD_LOAD_CFG) pmem_addr <= `ID_BASE;
      end
      if (prog_mode && load_cmd && is_id(pmem_addr)) begin
        id_mem[pmem_addr[`ID_IDX_W-1:0]] <= pl.wdata;
      end
      if (prog_mode && load_cmd && pmem_addr == `CFG_ADDR) begin
        cfg <= pl.wdata[7:0];
      end
    end
  end

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (sys_rst);

  sequence s_two_dummies;
    dummy_cycle ##1 dummy_cycle;
  endsequence

  sequence s_vector_out;
    vector_req && vector_pc == `VEC_ADDR;
  endsequence

  AST_SLEEP_ENTRY: assert property (sleep_go && !master_clear_pin_rst |=> sleeping && !osc_enable)
    else $error("Sleep not entered after sleep instruction.");

  AST_ENTRY_FLAGS: assert property (sleep_go && !wdt_to |=>
      !status_flags[`STATUS_PD] && status_flags[`STATUS_TO] && wdt_cnt == 16'h0000)
    else $error("Sleep entry did not update flags and watchdog.");

  AST_PIN_HOLD: assert property (pin_hold == sleeping && osc_enable == !sleeping)
    else $error("Pin hold does not match sleep state.");

  // A time-out in run may still clear the time-out flag during a no-operation sleep.
  AST_SLEEP_NOP: assert property (sleep_nop && !clear_watchdog_instr && !wdt_to |=>
      !sleeping && $stable(status_flags))
    else $error("Sleep with pending interrupt did not act as no-operation.");

  AST_WDT_WAKE: assert property (in_sleep && wdt_to && !master_clear_pin_rst |=>
      !status_flags[`STATUS_TO] && !device_reset && !sleeping)
    else $error("Watchdog wake-up reset the device or kept time-out set.");

  AST_IRQ_WAKE: assert property (in_sleep && wake_irq && !master_clear_pin_rst |=> !sleeping)
    else $error("Enabled interrupt did not wake the device.");

  AST_RC_NO_DELAY: assert property (in_sleep && wake && rc_osc_mode && !master_clear_pin_rst
      |=> resume_exec)
    else $error("RC mode wake-up was delayed.");

  AST_OST_COUNT: assert property (state == ST_OST && next_state == ST_NEXT
      |-> ost_cnt == OST_CYC_I - 1)
    else $error("Start-up delay ended at the wrong count.");

  // A master clear anywhere in the sequence legitimately cuts it short.
  AST_VECTOR: assert property (@(posedge mclk) disable iff (sys_rst || master_clear_pin_rst)
      state == ST_NEXT && global_irq_enable && irq_woke
      |=> s_two_dummies ##1 s_vector_out)
    else $error("Vector did not follow two dummy cycles.");

  AST_INLINE: assert property (state == ST_NEXT && !global_irq_enable
      |=> !dummy_cycle ##1 !vector_req)
    else $error("Wake with interrupts off did not continue inline.");

  AST_MASTER_CLEAR_PIN: assert property (master_clear_pin_rst |=> device_reset && !sleeping && !resume_exec)
    else $error("Master clear did not reset the device.");

  AST_PREFETCH: assert property (sleep_exec && in_run |=> prefetch_next)
    else $error("Next instruction was not prefetched.");

  AST_PROG_ENTRY: assert property (hv_rise && pl.pins_low && hv_s1
      |=> prog_mode ##1 pmem_addr == `PC_START)
    else $error("Program/verify mode not entered.");

  AST_PROTECT: assert property (prog_mode && is_pmem(pmem_addr) && !cp_off
      && $stable(pmem_addr) |=> pl.rdata == '0)
    else $error("Protected program memory was read out.");
endmodule // sleep_wakeup_control

// ===== prog_host_model.sv
// Serial programmer model that drives the two-wire programming link.
`timescale 1ns/1ps
module prog_host_model (
  output logic      pclk,
  output logic      pdat,
  output logic      pdat_oe,
  input  wire logic pin
);
  // Clock and data start low so that raising the high level enters program mode.
  initial begin
    pclk = 1'b0;
    pdat = 1'b0;
    pdat_oe = 1'b1;
  end
  // Half periods of 80 ns give the pin synchronisers ten core clocks of margin.
  // A command without a data word is sent with n set to 6.
  task automatic xfer(input logic [5:0] cmd, input logic [13:0] wd, input logic rd,
                      output logic [13:0] q, input int n = 20);
    for (int i = 0; i < n; i++) begin
      if (i == 6) begin
        pdat_oe = ~rd;
      end
      pdat = (i < 6) ? cmd[i] : wd[i-6];
      #80 pclk = 1'b1;
      #80 pclk = 1'b0;
      if (i > 5) begin
        q[i-6] = pin;
      end
    end
    pdat_oe = 1'b1;
    pdat = 1'b0;
  endtask
endmodule // prog_host_model

// ===== testbench.sv
// Self-checking bench for sleep entry, wake-up and the programming link.
`timescale 1ns/1ps
`include "sleep_wakeup_map.svh"
module testbench;
  import sleep_wakeup_pkg::*;
  logic mclk, sys_rst, sleep_exec, clear_watchdog_instr, global_irq_enable;
  logic ext_edge_irq_flag, ext_edge_irq_en, port_change_flag, port_change_en;
  logic adc_flag, adc_en, adc_rc_clock, reg_wr, master_clear_pin_n, rc_on;
  logic programming_high_level, wdt_rc_clock, osc_enable, pin_hold, sleeping;
  logic prefetch_next, resume_exec, dummy_cycle, vector_req, device_reset;
  logic prog_mode, prog_data_out, prog_data_oe, pmem_wr, pclk, host_d, host_oe;
  logic [7:0]  reg_addr, reg_wdata, reg_rdata, status_flags, rd;
  word_t       pmem_rdata, vector_pc, pmem_addr, pmem_wdata, q;
  wire         data_wire;
  int          fail_count, samples_checked;
  // Released data line floats to the pin's pull-up level.
  assign data_wire = prog_data_oe ? prog_data_out : (host_oe ? host_d : 1'b1);
  sleep_wakeup_control #(.WDT_BASE_TICKS(8'h04)) u_sleep_wakeup_control (
    .mclk(mclk), .sys_rst(sys_rst), .sleep_exec(sleep_exec),
    .clear_watchdog_instr(clear_watchdog_instr), .global_irq_enable(global_irq_enable),
    .ext_edge_irq_flag(ext_edge_irq_flag), .ext_edge_irq_en(ext_edge_irq_en),
    .port_change_flag(port_change_flag), .port_change_en(port_change_en),
    .adc_flag(adc_flag), .adc_en(adc_en), .adc_rc_clock(adc_rc_clock),
    .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
    .master_clear_pin_n(master_clear_pin_n), .programming_high_level(programming_high_level),
    .wdt_rc_clock(wdt_rc_clock), .prog_clock_pin(pclk), .prog_data_pin(data_wire),
    .pmem_rdata(pmem_rdata), .reg_rdata(reg_rdata), .status_flags(status_flags),
    .osc_enable(osc_enable), .pin_hold(pin_hold), .sleeping(sleeping),
    .prefetch_next(prefetch_next), .resume_exec(resume_exec), .dummy_cycle(dummy_cycle),
    .vector_req(vector_req), .vector_pc(vector_pc), .device_reset(device_reset),
    .prog_mode(prog_mode), .prog_data_out(prog_data_out), .prog_data_oe(prog_data_oe),
    .pmem_addr(pmem_addr), .pmem_wdata(pmem_wdata), .pmem_wr(pmem_wr));
  prog_host_model u_prog_host_model (.pclk(pclk), .pdat(host_d), .pdat_oe(host_oe),
    .pin(data_wire));
  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end
  always #20 if (rc_on) wdt_rc_clock = ~wdt_rc_clock;
  task automatic close_out();
    if (fail_count == 0 && samples_checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input logic ok, input string m);
    samples_checked++;
    if (ok !== 1'b1) begin
      fail_count++;
      $display("[FAIL] %0t %s", $time, m);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge mclk);
  endtask
  task automatic wait_hi(ref logic s, input int n);
    int k;
    k = 0;
    while (s !== 1'b1 && k < n) begin
      @(negedge mclk);
      k++;
    end
    chk(s === 1'b1, "wait ran out");
    if (s !== 1'b1) close_out();
  endtask
  task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
    cyc(1);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    cyc(1);
    reg_wr = 1'b0;
  endtask
  task automatic reg_read(input logic [7:0] a, output logic [7:0] d);
    cyc(1);
    reg_addr = a;
    cyc(1);
    d = reg_rdata;
  endtask
  // Leaves the bench at the negedge after the sleep edge, where entry outputs show.
  task automatic sleep_go();
    cyc(1);
    sleep_exec = 1'b1;
    cyc(1);
    sleep_exec = 1'b0;
  endtask
  initial begin
    {sleep_exec, clear_watchdog_instr, global_irq_enable, ext_edge_irq_flag} = 4'h0;
    {ext_edge_irq_en, port_change_flag, port_change_en, adc_flag, adc_en} = 5'h00;
    {adc_rc_clock, reg_wr, programming_high_level, wdt_rc_clock, rc_on} = 5'h00;
    {reg_addr, reg_wdata, pmem_rdata} = 30'h0;
    fail_count = 0;
    samples_checked = 0;
    master_clear_pin_n = 1'b1;
    sys_rst = 1'b1;
    cyc(10);
    sys_rst = 1'b0;
    chk(status_flags === `STATUS_RESET && osc_enable === 1'b1, "reset state");
    reg_read(`OPT_ADDR, rd);
    chk(rd === `OPT_RESET, "option reset");
    reg_write(8'h80, 8'h55);
    reg_read(8'h80, rd);
    chk(rd === 8'h00, "unmapped read");
    // The prescaler starts on the watchdog, so the count is cleared before the ratio changes.
    clear_watchdog_instr = 1'b1;
    cyc(1);
    clear_watchdog_instr = 1'b0;
    reg_write(`OPT_ADDR, 8'h07);
    reg_read(`OPT_ADDR, rd);
    chk(rd === 8'h07, "option readback");
    // Interrupt wake with the global enable on vectors after two dummy cycles.
    ext_edge_irq_en = 1'b1;
    global_irq_enable = 1'b1;
    sleep_go();
    chk(prefetch_next === 1'b1 && sleeping === 1'b1 && pin_hold === 1'b1, "entry");
    chk(osc_enable === 1'b0 && status_flags === 8'h10, "sleep flags");
    ext_edge_irq_flag = 1'b1;
    cyc(1);
    chk(resume_exec === 1'b1 && sleeping === 1'b0 && osc_enable === 1'b1, "irq wake");
    ext_edge_irq_flag = 1'b0;
    cyc(1);
    chk(dummy_cycle === 1'b1, "dummy one");
    cyc(1);
    chk(dummy_cycle === 1'b1, "dummy two");
    cyc(1);
    chk(vector_req === 1'b1 && vector_pc === `VEC_ADDR, "vector");
    clear_watchdog_instr = 1'b1;
    cyc(1);
    clear_watchdog_instr = 1'b0;
    // A pending enabled flag with the global enable off turns sleep into a no-operation.
    {port_change_en, port_change_flag, global_irq_enable} = 3'b110;
    sleep_go();
    chk(sleeping === 1'b0 && status_flags === 8'h18, "no-op sleep");
    {port_change_en, port_change_flag, ext_edge_irq_en} = 3'b000;
    sleep_go();
    ext_edge_irq_flag = 1'b1;
    cyc(3);
    chk(sleeping === 1'b1, "disabled source woke");
    {ext_edge_irq_flag, port_change_en, port_change_flag} = 3'b011;
    cyc(1);
    chk(resume_exec === 1'b1, "port change wake");
    port_change_flag = 1'b0;
    repeat (4) begin
      cyc(1);
      chk(vector_req === 1'b0, "vector with global off");
    end
    // Conversion wakes only when clocked from its own RC source.
    {port_change_en, adc_en} = 2'b01;
    sleep_go();
    adc_flag = 1'b1;
    cyc(3);
    chk(sleeping === 1'b1, "adc woke without rc");
    adc_rc_clock = 1'b1;
    wait_hi(resume_exec, 4);
    {adc_flag, adc_en, adc_rc_clock} = 3'b000;
    sleep_go();
    rc_on = 1'b1;
    wait_hi(resume_exec, 200);
    rc_on = 1'b0;
    chk(status_flags === 8'h00 && device_reset === 1'b0, "watchdog wake");
    sleep_go();
    master_clear_pin_n = 1'b0;
    wait_hi(device_reset, 6);
    master_clear_pin_n = 1'b1;
    sys_rst = 1'b1;
    cyc(2);
    sys_rst = 1'b0;
    programming_high_level = 1'b1;
    wait_hi(prog_mode, 10);
    chk(pmem_addr === `PC_START, "start address");
    pmem_rdata = 14'h2A5C;
    u_prog_host_model.xfer(`CMD_READ, 14'h0000, 1'b1, q);
    chk(q === 14'h2A5C, "readout");
    // The write word is only valid beside its strobe, so it is compared there.
    fork
      u_prog_host_model.xfer(`CMD_LOAD, 14'h01B3, 1'b0, q);
      begin
        wait_hi(pmem_wr, 450);
        chk(pmem_wdata === 14'h01B3, "load word");
      end
    join
    // ID word zero, then a configuration word with crystal mode and protection on.
    u_prog_host_model.xfer(`CMD_LOAD_CFG, 14'h0000, 1'b0, q);
    u_prog_host_model.xfer(`CMD_LOAD, 14'h000A, 1'b0, q);
    u_prog_host_model.xfer(`CMD_READ, 14'h0000, 1'b1, q);
    chk(q === 14'h000A, "id word");
    repeat (7) u_prog_host_model.xfer(`CMD_INC, 14'h0000, 1'b0, q, 6);
    u_prog_host_model.xfer(`CMD_LOAD, 14'h0088, 1'b0, q);
    programming_high_level = 1'b0;
    cyc(4);
    programming_high_level = 1'b1;
    wait_hi(prog_mode, 10);
    chk(pmem_addr === `PC_START, "restart address");
    u_prog_host_model.xfer(`CMD_READ, 14'h0000, 1'b1, q);
    chk(q === 14'h0000, "protected readout");
    programming_high_level = 1'b0;
    cyc(4);
    // Crystal mode holds the core for the full start-up delay after wake.
    ext_edge_irq_en = 1'b1;
    sleep_go();
    ext_edge_irq_flag = 1'b1;
    cyc(1);
    chk(sleeping === 1'b0 && resume_exec === 1'b0, "start-up skipped");
    ext_edge_irq_flag = 1'b0;
    cyc(1023);
    chk(resume_exec === 1'b0, "start-up too short");
    cyc(1);
    chk(resume_exec === 1'b1, "start-up end");
    close_out();
  end
endmodule // testbench
